// file: src/evp_pkg.sv
package evp_pkg;
	localparam int EVP_NPORT = 5;
	localparam int EVP_PINS = 32;
	localparam int EVP_NCB = 6;
	localparam int EVP_CBW = 3;
	localparam int EVP_CB_DIVW = 8;
	localparam int EVP_CNT_W = 16;
	localparam int EVP_AW = 8;
	// Nominal port widths, narrowest first; every port starts at pin 0
	localparam int EVP_PW [EVP_NPORT] = '{1, 4, 8, 16, 32};
	// Clock timing
	localparam int EVP_CLK_MHZ = 100;
	localparam int EVP_REF_MHZ = 100;
	localparam int EVP_REF_DIV = EVP_CLK_MHZ / EVP_REF_MHZ;
	// Address map: addr[7:5] page, addr[4:0] byte offset in page
	localparam logic [2:0] EVP_CB_PAGE = 3'h5;
	localparam logic [4:0] EVP_REG_CTRL = 5'h00;
	localparam logic [4:0] EVP_REG_COND = 5'h04;
	localparam logic [4:0] EVP_REG_DATA = 5'h08;
	localparam logic [4:0] EVP_REG_COUNT = 5'h0C;
	localparam logic [4:0] EVP_REG_TIME = 5'h10;
	localparam logic [4:0] EVP_REG_STAT = 5'h14;
	// Control register fields
	localparam int EVP_CTL_EN = 0;
	localparam int EVP_CTL_DIR = 1;
	localparam int EVP_CTL_OD = 2;
	localparam int EVP_CTL_CLK = 3;
	localparam int EVP_CTL_COND = 6;
	localparam int EVP_CTL_STB = 8;
	// Status register fields, timestamp in the low bits
	localparam int EVP_ST_FULL = 16;
	localparam int EVP_ST_TIMED = 17;
	// Clock block register fields
	localparam int EVP_CBF_EXT = 8;
	typedef enum logic [1:0] {EVP_COND_NONE, EVP_COND_EQ, EVP_COND_NEQ} evp_cond_t;
endpackage

// file: src/evp_cb_if.sv
`timescale 1ns/1ps
interface evp_cb_if import evp_pkg::*; ();
	logic [EVP_NCB-1:0][EVP_CB_DIVW-1:0] div;
	logic [EVP_NCB-1:0] ext_sel;
	logic ext_clk;
	logic [EVP_NCB-1:0] tick;
	modport ctl (output div, output ext_sel, output ext_clk, input tick);
	modport blk (input div, input ext_sel, input ext_clk, output tick);
endinterface

// file: src/evp_clock_block.sv
`timescale 1ns/1ps
module evp_clock_block import evp_pkg::*; (
	input wire logic core_clk,
	input wire logic srst,
	evp_cb_if.blk cb
);
	typedef struct packed {
		logic [EVP_NCB-1:0][EVP_CB_DIVW-1:0] cnt;
		logic ext_prev;
		logic [EVP_NCB-1:0] tick;
	} evp_cbst_t;

	evp_cbst_t st, next_st;

	if (EVP_REF_DIV < 1 || EVP_REF_DIV > 255) begin : g_chk
		$error("reference divide out of range");
	end

	assign cb.tick = st.tick;

	always_comb begin
		logic ext_rise;
		logic step;
		ext_rise = cb.ext_clk && !st.ext_prev;
		step = 1'b0;
		next_st = st;
		next_st.ext_prev = cb.ext_clk;
		next_st.tick = '0;
		for (int b = 0; b < EVP_NCB; b++) begin
			if (b == 0) begin
				// Block 0 is fixed to the tile reference rate
				if (st.cnt[b] >= EVP_CB_DIVW'(EVP_REF_DIV - 1)) begin
					next_st.cnt[b] = '0;
					next_st.tick[b] = 1'b1;
				end else begin
					next_st.cnt[b] = st.cnt[b] + EVP_CB_DIVW'(1);
				end
			end else begin
				// External source is the synced 1-bit port pin, optionally divided
				step = cb.ext_sel[b] ? ext_rise : 1'b1;
				if (step) begin
					// Own programmable rate: one tick per div+1 steps
					if (st.cnt[b] >= cb.div[b]) begin
						next_st.cnt[b] = '0;
						next_st.tick[b] = 1'b1;
					end else begin
						next_st.cnt[b] = st.cnt[b] + EVP_CB_DIVW'(1);
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// file: src/evp_port_bank.sv
`timescale 1ns/1ps
module evp_port_bank import evp_pkg::*; #(
	parameter int CNT_W = EVP_CNT_W
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [EVP_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [EVP_PINS-1:0] pin_in,
	output logic [EVP_PINS-1:0] pin_out,
	output logic [EVP_PINS-1:0] pin_oe,
	input wire logic [EVP_PINS-1:0] link_pin_mask,
	input wire logic [EVP_NPORT-1:0] ready_in,
	output logic [EVP_NPORT-1:0] output_strobe,
	output logic [EVP_NPORT-1:0] port_event
);
	if (CNT_W < 2 || CNT_W > 16) begin : g_chk
		$error("CNT_W must be 2 to 16");
	end

	typedef struct packed {
		logic en;
		logic dir;
		logic od;
		logic stb_en;
		logic [EVP_CBW-1:0] clk;
		evp_cond_t cond;
		logic [EVP_PINS-1:0] cond_val;
		logic [EVP_PINS-1:0] xfer;
		logic [EVP_PINS-1:0] shift;
		logic full;
		logic timed;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] tmark;
		logic [CNT_W-1:0] tstamp;
	} evp_pst_t;

	typedef struct packed {
		evp_pst_t [EVP_NPORT-1:0] p;
		logic [EVP_NCB-1:0][EVP_CB_DIVW-1:0] cb_div;
		logic [EVP_NCB-1:0] cb_ext;
		logic [EVP_PINS-1:0] pin_s1;
		logic [EVP_PINS-1:0] pin_s2;
		logic [EVP_PINS-1:0] pin_out;
		logic [EVP_PINS-1:0] pin_oe;
		logic [EVP_NPORT-1:0] rdy_s1;
		logic [EVP_NPORT-1:0] rdy_s2;
		logic [EVP_NPORT-1:0] evt;
		logic [EVP_NPORT-1:0] ostb;
		logic [31:0] rdata;
	} evp_bank_t;

	evp_bank_t st, next_st;
	logic [EVP_NPORT-1:0] port_tick;
	evp_cb_if cb ();

	function automatic logic [EVP_PINS-1:0] wmask(input int w);
		logic [EVP_PINS:0] m;
		m = (EVP_PINS+1)'(1) << w;
		return EVP_PINS'(m - (EVP_PINS+1)'(1));
	endfunction

	evp_clock_block u_clk (
		.core_clk(core_clk),
		.srst(srst),
		.cb(cb.blk)
	);

	assign cb.div = st.cb_div;
	assign cb.ext_sel = st.cb_ext;
	// The 1-bit port pin feeds the clock blocks after synchronising
	assign cb.ext_clk = st.pin_s2[0];

	assign reg_rdata = st.rdata;
	assign pin_out = st.pin_out;
	assign pin_oe = st.pin_oe;
	assign output_strobe = st.ostb;
	assign port_event = st.evt;

	always_comb begin
		logic [EVP_PINS-1:0] pm;
		logic [EVP_PINS-1:0] wd;
		logic cond_ok;
		logic time_ok;
		logic found;
		logic [2:0] pg;
		logic [4:0] ro;
		pm = '0;
		wd = '0;
		cond_ok = 1'b0;
		time_ok = 1'b0;
		found = 1'b0;
		pg = reg_addr[7:5];
		ro = reg_addr[4:0];
		next_st = st;
		port_tick = '0;
		next_st.pin_s1 = pin_in;
		next_st.pin_s2 = st.pin_s1;
		next_st.rdy_s1 = ready_in;
		next_st.rdy_s2 = st.rdy_s1;
		next_st.evt = '0;
		next_st.ostb = '0;
		next_st.rdata = '0;

		// Pin side of every port, stepped by its clock block
		for (int i = 0; i < EVP_NPORT; i++) begin
			// Sampling covers the whole nominal width
			pm = st.pin_s2 & wmask(EVP_PW[i]);
			port_tick[i] = cb.tick[st.p[i].clk];
			time_ok = !st.p[i].timed || (st.p[i].cnt == st.p[i].tmark);
			case (st.p[i].cond)
				EVP_COND_EQ: begin
					cond_ok = (pm == st.p[i].cond_val);
				end
				EVP_COND_NEQ: begin
					cond_ok = (pm != st.p[i].cond_val);
				end
				default: begin
					cond_ok = 1'b1;
				end
			endcase
			if (st.p[i].en && port_tick[i]) begin
				next_st.p[i].cnt = st.p[i].cnt + CNT_W'(1);
				if (st.p[i].dir) begin
					if (st.p[i].full && time_ok) begin
						// Transfer register to shift stage
						next_st.p[i].shift = st.p[i].xfer;
						next_st.p[i].full = 1'b0;
						next_st.p[i].timed = 1'b0;
						next_st.p[i].tstamp = st.p[i].cnt;
						next_st.ostb[i] = 1'b1;
					end
				end else begin
					next_st.p[i].shift = pm;
					// Input strobe gates the capture when enabled
					if (!st.p[i].full && time_ok && cond_ok &&
							(!st.p[i].stb_en || st.rdy_s2[i])) begin
						next_st.p[i].xfer = pm;
						next_st.p[i].full = 1'b1;
						next_st.p[i].timed = 1'b0;
						next_st.p[i].tstamp = st.p[i].cnt;
						next_st.evt[i] = 1'b1;
					end
				end
			end
		end

		// Register access, answered in the cycle after the strobe
		if (pg < 3'(EVP_NPORT)) begin
			for (int i = 0; i < EVP_NPORT; i++) begin
				if (pg == 3'(i)) begin
					wd = reg_wdata & wmask(EVP_PW[i]);
					if (reg_wr) begin
						if (ro == EVP_REG_CTRL) begin
							next_st.p[i].en = reg_wdata[EVP_CTL_EN];
							// One direction and one drive mode per port
							next_st.p[i].dir = reg_wdata[EVP_CTL_DIR];
							next_st.p[i].od = reg_wdata[EVP_CTL_OD];
							next_st.p[i].stb_en = reg_wdata[EVP_CTL_STB];
							next_st.p[i].cond = evp_cond_t'(reg_wdata[EVP_CTL_COND +: 2]);
							if (reg_wdata[EVP_CTL_CLK +: EVP_CBW] < EVP_CBW'(EVP_NCB)) begin
								next_st.p[i].clk = reg_wdata[EVP_CTL_CLK +: EVP_CBW];
							end else begin
								next_st.p[i].clk = '0;
							end
						end else if (ro == EVP_REG_COND) begin
							next_st.p[i].cond_val = wd;
						end else if (ro == EVP_REG_DATA) begin
							// Newest write replaces a pending word
							if (st.p[i].dir) begin
								next_st.p[i].xfer = wd;
								next_st.p[i].full = 1'b1;
							end
						end else if (ro == EVP_REG_TIME) begin
							next_st.p[i].tmark = reg_wdata[CNT_W-1:0];
							next_st.p[i].timed = 1'b1;
						end
					end
					if (reg_rd) begin
						if (ro == EVP_REG_CTRL) begin
							next_st.rdata[EVP_CTL_EN] = st.p[i].en;
							next_st.rdata[EVP_CTL_DIR] = st.p[i].dir;
							next_st.rdata[EVP_CTL_OD] = st.p[i].od;
							next_st.rdata[EVP_CTL_STB] = st.p[i].stb_en;
							next_st.rdata[EVP_CTL_CLK +: EVP_CBW] = st.p[i].clk;
							next_st.rdata[EVP_CTL_COND +: 2] = st.p[i].cond;
						end else if (ro == EVP_REG_COND) begin
							next_st.rdata = st.p[i].cond_val;
						end else if (ro == EVP_REG_DATA) begin
							next_st.rdata = st.p[i].xfer;
							// A capture in this same cycle keeps its full flag
							if (!st.p[i].dir && !next_st.evt[i]) begin
								next_st.p[i].full = 1'b0;
							end
						end else if (ro == EVP_REG_COUNT) begin
							next_st.rdata[CNT_W-1:0] = st.p[i].cnt;
						end else if (ro == EVP_REG_TIME) begin
							next_st.rdata[CNT_W-1:0] = st.p[i].tmark;
						end else if (ro == EVP_REG_STAT) begin
							next_st.rdata[CNT_W-1:0] = st.p[i].tstamp;
							next_st.rdata[EVP_ST_FULL] = st.p[i].full;
							next_st.rdata[EVP_ST_TIMED] = st.p[i].timed;
						end
					end
				end
			end
		end else if (pg == EVP_CB_PAGE && ro[1:0] == 2'h0) begin
			for (int b = 0; b < EVP_NCB; b++) begin
				if (ro[4:2] == 3'(b)) begin
					// Block 0 stays on the reference clock, writes ignored
					if (reg_wr && b != 0) begin
						next_st.cb_div[b] = reg_wdata[EVP_CB_DIVW-1:0];
						next_st.cb_ext[b] = reg_wdata[EVP_CBF_EXT];
					end
					if (reg_rd) begin
						next_st.rdata[EVP_CB_DIVW-1:0] = st.cb_div[b];
						next_st.rdata[EVP_CBF_EXT] = st.cb_ext[b];
					end
				end
			end
		end

		// Pin ownership: link first, then the narrowest enabled port
		for (int j = 0; j < EVP_PINS; j++) begin
			found = link_pin_mask[j];
			next_st.pin_oe[j] = 1'b0;
			next_st.pin_out[j] = 1'b0;
			for (int i = 0; i < EVP_NPORT; i++) begin
				if (!found && st.p[i].en && j < EVP_PW[i]) begin
					found = 1'b1;
					if (st.p[i].dir) begin
						if (st.p[i].od) begin
							next_st.pin_oe[j] = !st.p[i].shift[j];
						end else begin
							next_st.pin_out[j] = st.p[i].shift[j];
							next_st.pin_oe[j] = 1'b1;
						end
					end
				end
			end
		end
	end

	// Reset clears every port to clock block 0 and input mode
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	chk_reset_block_zero: assert property ($fell(srst) |-> st.p[4].clk == '0 && st.p[0].clk == '0)
		else $error("port not on clock block 0 after reset");

	chk_counter_step: assert property (st.p[2].en && port_tick[2] |=>
		st.p[2].cnt == $past(st.p[2].cnt) + CNT_W'(1))
		else $error("port counter did not step on tick");

	chk_counter_hold: assert property (!port_tick[2] |=> st.p[2].cnt == $past(st.p[2].cnt))
		else $error("port counter moved without tick");

	chk_count_read: assert property (reg_rd && reg_addr == {3'h0, EVP_REG_COUNT} |=>
		reg_rdata == 32'($past(st.p[0].cnt)))
		else $error("counter read data wrong or late");

	chk_timestamp_capture: assert property ($rose(port_event[1]) |->
		st.p[1].tstamp == $past(st.p[1].cnt) && st.p[1].full)
		else $error("timestamp not captured with event");

	chk_open_drain_low: assert property (st.p[0].en && st.p[0].dir && st.p[0].od &&
		!link_pin_mask[0] |=> !pin_out[0] && pin_oe[0] == !$past(st.p[0].shift[0]))
		else $error("open-drain pin drove high");

	chk_narrow_wins: assert property (st.p[0].en && !st.p[0].dir && st.p[1].en &&
		st.p[1].dir ##1 st.p[0].en && !st.p[0].dir |-> !pin_oe[0])
		else $error("wider port drove a pin owned by narrow port");

	chk_link_owns: assert property (link_pin_mask[31] [*2] |-> !pin_oe[31])
		else $error("port drove a link pin");

	chk_timed_wait: assert property (st.p[3].dir && st.p[3].timed &&
		st.p[3].cnt != st.p[3].tmark |=> !output_strobe[3])
		else $error("timed output left before its counter value");

	chk_out_strobe_move: assert property (output_strobe[2] |->
		!st.p[2].full || $past(reg_wr))
		else $error("output strobe without transfer");

	// Read data is a one-cycle answer, zero between reads
	chk_read_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero outside a read");

	chk_event_single: assert property (port_event[2] |=> !port_event[2])
		else $error("input event longer than one cycle");

	chk_input_released: assert property (st.p[2].en && !st.p[2].dir && !st.p[0].en &&
		!st.p[1].en |=> pin_oe[7:0] == 8'h00)
		else $error("input port drove its pins");

	chk_ref_tick: assert property (!$past(srst) |-> cb.tick[0])
		else $error("reference block missed a tick");

	chk_od_pins_low: assert property (st.p[1].en && st.p[1].dir && st.p[1].od |=>
		!pin_out[1] && !pin_out[3])
		else $error("open-drain port drove a pin high");

	chk_timed_leaves: assert property (st.p[3].en && st.p[3].dir && st.p[3].full &&
		st.p[3].timed && port_tick[3] && st.p[3].cnt == st.p[3].tmark |=> output_strobe[3])
		else $error("timed output missed its counter value");

	cov_input_event: cover property (st.p[2].cond == EVP_COND_EQ ##1 port_event[2]);
	cov_output_strobe: cover property (st.p[0].od ##1 output_strobe[0]);
	cov_timed_transfer: cover property (st.p[3].timed ##1 !st.p[3].timed && output_strobe[3]);
	cov_ext_clock: cover property (st.cb_ext[2] && port_tick[1] && st.p[1].clk == 3'h2);
	cov_narrow_owner: cover property (st.p[0].en && !st.p[0].dir && st.p[1].en && st.p[1].dir);
endmodule

// file: tb/evp_pin_partner.sv
`timescale 1ns/1ps
module evp_pin_partner import evp_pkg::*; (
	input wire logic [EVP_PINS-1:0] pin_out,
	input wire logic [EVP_PINS-1:0] pin_oe,
	input wire logic [EVP_PINS-1:0] ext_val,
	input wire logic [EVP_PINS-1:0] ext_en,
	input wire logic [EVP_NPORT-1:0] ext_rdy,
	output logic [EVP_PINS-1:0] pin_in,
	output logic [EVP_NPORT-1:0] ready_in
);
	// A pin nobody drives falls to its pull-down, never holds the last value
	always_comb begin
		for (int i = 0; i < EVP_PINS; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b0);
		end
	end
	assign ready_in = ext_rdy;
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import evp_pkg::*; ;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [EVP_AW-1:0] addr = '0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata, v, t;
	logic [EVP_PINS-1:0] pin_out, pin_oe, pin_in;
	logic [EVP_PINS-1:0] link = '0;
	logic [EVP_PINS-1:0] ext_val = '0;
	logic [EVP_PINS-1:0] ext_en = '0;
	logic [EVP_NPORT-1:0] ext_rdy = '0;
	logic [EVP_NPORT-1:0] ready_in, strobe, evt;
	int bad_count = 0;
	int num_checks = 0;
	evp_port_bank uut (.core_clk(core_clk), .srst(srst), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .link_pin_mask(link), .ready_in(ready_in), .output_strobe(strobe),
		.port_event(evt));
	evp_pin_partner far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
		.ext_en(ext_en), .ext_rdy(ext_rdy), .pin_in(pin_in), .ready_in(ready_in));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wreg(input int p, input logic [4:0] off, input logic [31:0] d);
		@(posedge core_clk);
		addr <= {3'(p), off};
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input int p, input logic [4:0] off, output logic [31:0] d);
		@(posedge core_clk);
		addr <= {3'(p), off};
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_hi(input int p, input bit out);
		int i;
		for (i = 0; i < 300; i++) begin
			@(posedge core_clk);
			#1;
			if ((out ? strobe[p] : evt[p]) === 1'b1) break;
		end
		if (i == 300) begin
			bad_count++;
			$display("unexpected pulse: expected 1 seen 0");
			complete_run();
		end
	endtask
	task automatic no_evt(input int p);
		repeat (20) begin
			@(posedge core_clk);
			#1 chk("idle event", 32'(evt[p]), 32'h0);
		end
	endtask
	task automatic t_reset();
		#1 chk("oe at reset", pin_oe, 32'h0);
		rreg(4, EVP_REG_CTRL, v);
		chk("ctrl reset", v, 32'h0);
		rreg(0, 5'h18, v);
		chk("unmapped", v, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_out();
		wreg(0, EVP_REG_CTRL, 32'h3);
		wreg(0, EVP_REG_DATA, 32'h1);
		wait_hi(0, 1);
		@(posedge core_clk);
		#1 chk("pin0", 32'({pin_oe[0], pin_out[0]}), 32'h3);
		wreg(0, EVP_REG_CTRL, 32'h0);
		wreg(2, EVP_REG_CTRL, 32'h3);
		wreg(2, EVP_REG_DATA, 32'hFFFFFFFF);
		wait_hi(2, 1);
		@(posedge core_clk);
		#1 chk("oe8", pin_oe, 32'h000000FF);
		chk("out8", pin_out, 32'h000000FF);
		wreg(4, EVP_REG_CTRL, 32'h3);
		wreg(4, EVP_REG_DATA, 32'h12345678);
		// Narrow port in open drain over two wider push-pull ports
		wreg(1, EVP_REG_CTRL, 32'h7);
		wreg(1, EVP_REG_DATA, 32'hA);
		wait_hi(1, 1);
		@(posedge core_clk);
		#1 chk("oe mix", pin_oe, 32'hFFFFFFF5);
		chk("out mix", pin_out & pin_oe, 32'h123456F0);
		@(posedge core_clk);
		link <= 32'hF0000000;
		repeat (3) @(posedge core_clk);
		#1 chk("oe link", pin_oe, 32'h0FFFFFF5);
		@(posedge core_clk);
		link <= '0;
		for (int p = 0; p < EVP_NPORT; p++) begin
			wreg(p, EVP_REG_CTRL, 32'h0);
		end
		$display("test output done");
	endtask
	task automatic t_in();
		@(posedge core_clk);
		ext_en <= 32'h000000FF;
		ext_val <= 32'h5A;
		repeat (3) @(posedge core_clk);
		wreg(2, EVP_REG_CTRL, 32'h1);
		wait_hi(2, 0);
		rreg(2, EVP_REG_STAT, v);
		rreg(2, EVP_REG_COUNT, t);
		chk("full", 32'(v[EVP_ST_FULL]), 32'h1);
		chk("stamp age", 32'((t[15:0] - v[15:0]) < 16'h10), 32'h1);
		rreg(2, EVP_REG_DATA, v);
		chk("data in", v, 32'h5A);
		wreg(2, EVP_REG_COND, 32'h33);
		wreg(2, EVP_REG_CTRL, 32'h41);
		rreg(2, EVP_REG_DATA, v);
		no_evt(2);
		@(posedge core_clk);
		ext_val <= 32'h33;
		wait_hi(2, 0);
		rreg(2, EVP_REG_DATA, v);
		chk("cond eq", v, 32'h33);
		wreg(2, EVP_REG_CTRL, 32'h81);
		rreg(2, EVP_REG_DATA, v);
		no_evt(2);
		@(posedge core_clk);
		ext_val <= 32'h34;
		wait_hi(2, 0);
		rreg(2, EVP_REG_DATA, v);
		chk("cond neq", v, 32'h34);
		wreg(2, EVP_REG_CTRL, 32'h101);
		rreg(2, EVP_REG_DATA, v);
		no_evt(2);
		@(posedge core_clk);
		ext_rdy <= 5'h04;
		wait_hi(2, 0);
		$display("test input done");
	endtask
	task automatic t_clk();
		logic [31:0] a, b;
		wreg(5, 5'h04, 32'h3);
		wreg(3, EVP_REG_CTRL, 32'h9);
		wreg(0, EVP_REG_CTRL, 32'h1);
		rreg(3, EVP_REG_COUNT, v);
		rreg(0, EVP_REG_COUNT, t);
		repeat (36) @(posedge core_clk);
		rreg(3, EVP_REG_COUNT, a);
		rreg(0, EVP_REG_COUNT, b);
		chk("ref rate", 32'(b[15:0] - t[15:0]), 32'd40);
		chk("div rate", 32'(a[15:0] - v[15:0]), 32'd10);
		// Pin 0 as clock source, divided by two
		wreg(5, 5'h08, 32'h101);
		wreg(1, EVP_REG_CTRL, 32'h11);
		rreg(1, EVP_REG_COUNT, v);
		repeat (8) begin
			repeat (4) @(posedge core_clk);
			ext_val[0] <= 1'b1;
			repeat (4) @(posedge core_clk);
			ext_val[0] <= 1'b0;
		end
		repeat (4) @(posedge core_clk);
		rreg(1, EVP_REG_COUNT, a);
		chk("ext rate", 32'(a[15:0] - v[15:0]), 32'd4);
		$display("test clock done");
	endtask
	task automatic t_time();
		// Port 1 drives while port 0 still samples pin 0
		wreg(1, EVP_REG_CTRL, 32'h3);
		repeat (2) @(posedge core_clk);
		#1 chk("narrow in", pin_oe & 32'hF, 32'hE);
		wreg(0, EVP_REG_CTRL, 32'h7);
		wreg(0, EVP_REG_DATA, 32'h0);
		wait_hi(0, 1);
		@(posedge core_clk);
		#1 chk("od low", 32'({pin_oe[0], pin_out[0]}), 32'h2);
		// Output held back until the counter reaches the mark
		wreg(3, EVP_REG_CTRL, 32'h3);
		rreg(3, EVP_REG_COUNT, v);
		wreg(3, EVP_REG_TIME, v + 32'd40);
		wreg(3, EVP_REG_DATA, 32'h0000BEEF);
		wait_hi(3, 1);
		rreg(3, EVP_REG_STAT, t);
		chk("timed stamp", t, {16'h0, v[15:0] + 16'd40});
		@(posedge core_clk);
		#1 chk("timed pins", pin_out & 32'hFFFFFF00, 32'h0000BE00);
		$display("test timed done");
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		t_reset();
		t_out();
		t_in();
		t_clk();
		t_time();
		complete_run();
	end
endmodule
